//--- include/dpa_defs.svh
// Constants of the debug port acquire and select block
`ifndef DPA_DEFS_SVH
`define DPA_DEFS_SVH

// System clock rate and the post-reset key window
`define DPA_CLK_MHZ 200
`define DPA_WIN_NS 8000
`define DPA_WIN_CYC ((`DPA_WIN_NS * `DPA_CLK_MHZ) / 1000)
`define DPA_WIN_W 11

// Acquire sequence: length and pattern, oldest bit in the top position
`define DPA_ACQ_LEN 16
`define DPA_ACQ_PAT 16'h9e5b

// Lockout key (arbitrary value) and least count of matching bits
`define DPA_LOCK_W 32
`define DPA_LOCK_KEY 32'h1b7cd249
`define DPA_LOCK_MIN 6'h1c
`define DPA_CNT_W 6

// Port-select setting codes
`define DPA_DPS_JTAG4 2'h0
`define DPA_DPS_JTAG5 2'h1
`define DPA_DPS_SWD 2'h2
`define DPA_DPS_OFF 2'h3

// Test port instructions and data register lengths
`define DPA_IR_W 4
`define DPA_IR_CAPT 4'h1
`define DPA_IR_SCAN 4'h2
`define DPA_IR_CTRL 4'h8
`define DPA_IR_BYP 4'hf
`define DPA_DR_W 8
`define DPA_LEN_W 4
`define DPA_LEN_SCAN 4'h8
`define DPA_LEN_CTRL 4'h2
`define DPA_LEN_BYP 4'h1
`define DPA_TCTRL_RST 0
`define DPA_TCTRL_SWD 1

// Firmware register port
`define DPA_ADDR_W 4
`define DPA_A_CTRL 4'h0
`define DPA_A_STAT 4'h4
`define DPA_CTRL_W 3
`define DPA_CTRL_RST 3'h0
`define DPA_C_JTAG_OFF 0
`define DPA_C_SWD_OFF 1
`define DPA_C_DBG_EN 2

`endif

//--- include/dpa_pkg.sv
// Types of the debug port acquire and select block
`default_nettype none
package dpa_pkg;

    // Port ownership after reset
    typedef enum logic [5:0] {
        M_WAIT = 6'h01,
        M_WIN  = 6'h02,
        M_JTAG = 6'h04,
        M_SWDJ = 6'h08,
        M_SWDU = 6'h10,
        M_OFF  = 6'h20
    } dpa_mode_t;

    // Test access port controller states
    typedef enum logic [15:0] {
        T_TLR  = 16'h0001,
        T_RTI  = 16'h0002,
        T_SDR  = 16'h0004,
        T_CDR  = 16'h0008,
        T_SHDR = 16'h0010,
        T_E1DR = 16'h0020,
        T_PDR  = 16'h0040,
        T_E2DR = 16'h0080,
        T_UDR  = 16'h0100,
        T_SIR  = 16'h0200,
        T_CIR  = 16'h0400,
        T_SHIR = 16'h0800,
        T_E1IR = 16'h1000,
        T_PIR  = 16'h2000,
        T_E2IR = 16'h4000,
        T_UIR  = 16'h8000
    } dpa_tap_t;

    // Levels arriving on the debug pins
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
        logic usb_dp;
        logic usb_dm;
    } dpa_pin_in_t;

    // Drive toward the debug pins
    typedef struct packed {
        logic tdo;
        logic tdo_oe;
        logic tms;
        logic tms_oe;
        logic usb_dm;
        logic usb_dm_oe;
    } dpa_pin_out_t;

endpackage
`default_nettype wire

//--- hdl/dpa_acq_det.sv
// Acquire sequence detector for one serial-wire pin pair
`timescale 1ns/1ps
`default_nettype none
`include "dpa_defs.svh"

module dpa_acq_det (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    // Sampled pin pair
    input wire logic i_arm,
    input wire logic i_clk_rise,
    input wire logic i_bit,
    // Result
    output logic o_hit
);

    logic [`DPA_ACQ_LEN-1:0] sh_reg;
    logic [`DPA_ACQ_LEN-1:0] sh_next;
    logic hit_reg;
    logic hit_next;
    logic take;

    // A bit is taken on each rising data clock while the window is open
    assign take = i_arm & i_clk_rise;
    assign sh_next = take ? {sh_reg[`DPA_ACQ_LEN-2:0], i_bit} : sh_reg;
    assign hit_next = take & (sh_next == `DPA_ACQ_PAT);

    // History is dropped outside the window so no stale bits match later
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sh_reg <= '0;
            hit_reg <= 1'b0;
        end else begin
            sh_reg <= i_arm ? sh_next : '0;
            hit_reg <= hit_next;
        end
    end

    assign o_hit = hit_reg;

endmodule
`default_nettype wire

//--- hdl/dpa_top.sv
// Debug port selection, serial-wire acquire and test access port
`timescale 1ns/1ps
`default_nettype none
`include "dpa_defs.svh"

module dpa_top (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    // Nonvolatile settings, stable after reset
    input wire logic [1:0] i_debug_port_select_setting,
    input wire logic [`DPA_LOCK_W-1:0] i_write_once_lock_latch,
    // Debug pins
    input wire dpa_pkg::dpa_pin_in_t i_pins,
    output dpa_pkg::dpa_pin_out_t o_pins,
    // Boundary scan cells
    input wire logic [`DPA_DR_W-1:0] i_bscan_in,
    output logic [`DPA_DR_W-1:0] o_bscan_out,
    // Serial-wire protocol engine
    output logic o_swd_clk_rise,
    output logic o_swd_bit,
    input wire logic i_swd_out,
    input wire logic i_swd_oe,
    input wire logic i_swd_jtag_reen,
    // Firmware register port
    input wire logic [`DPA_ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Port and debug state
    output logic o_jtag_en,
    output logic o_swd_jtag_pair_en,
    output logic o_swd_usb_pair_en,
    output logic o_dbg_trace_en,
    output logic o_locked,
    output logic o_dev_rst_req
);

    dpa_pkg::dpa_mode_t mode_reg;
    dpa_pkg::dpa_mode_t mode_next;
    dpa_pkg::dpa_tap_t tap_reg;
    dpa_pkg::dpa_tap_t tap_next;
    dpa_pkg::dpa_pin_in_t p;
    dpa_pkg::dpa_pin_in_t q;
    logic [5:0] s1_reg;
    logic [5:0] s2_reg;
    logic [5:0] s3_reg;
    logic [1:0] dps_reg;
    logic locked_reg;
    logic [`DPA_WIN_W-1:0] win_reg;
    logic [`DPA_CTRL_W-1:0] ctrl_reg;
    logic [31:0] rdata_reg;
    logic [`DPA_IR_W-1:0] ir_reg;
    logic [`DPA_IR_W-1:0] ir_sh_reg;
    logic [`DPA_DR_W-1:0] dr_reg;
    logic [`DPA_DR_W-1:0] dr_sh;
    logic [`DPA_DR_W-1:0] scan_reg;
    logic [`DPA_LEN_W-1:0] dr_len;
    logic [`DPA_CNT_W-1:0] match_cnt;
    logic tdo_reg;
    logic tdo_oe_reg;
    logic rst_req_reg;
    logic swd_bit_reg;
    logic [`DPA_LOCK_W-1:0] key_eq;

    // Pins come from the host's clock domain: two flops, then an edge stage
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= i_pins;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Edges seen at 200 MHz; host clock ratio limits keep phases wide enough
    wire tck_rise = p.tck & ~q.tck;
    wire tck_fall = ~p.tck & q.tck;
    wire dp_rise = p.usb_dp & ~q.usb_dp;
    assign p = dpa_pkg::dpa_pin_in_t'(s2_reg);
    assign q = dpa_pkg::dpa_pin_in_t'(s3_reg);

    // Lock pattern compare: bit matches counted for the super-majority
    assign key_eq = ~(i_write_once_lock_latch ^ `DPA_LOCK_KEY);
    always_comb begin
        match_cnt = '0;
        for (int i = 0; i < `DPA_LOCK_W; i++) begin
            match_cnt = match_cnt + `DPA_CNT_W'(key_eq[i]);
        end
    end

    // Settings are caught once, at the first edge after reset release
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            dps_reg <= `DPA_DPS_JTAG4;
            locked_reg <= 1'b1;
        end else if (mode_reg == dpa_pkg::M_WAIT) begin
            dps_reg <= i_debug_port_select_setting;
            locked_reg <= (match_cnt >= `DPA_LOCK_MIN);
        end
    end

    // Key window timing
    wire win_end = (win_reg == `DPA_WIN_W'(`DPA_WIN_CYC - 1));
    wire in_win = (mode_reg == dpa_pkg::M_WIN);
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            win_reg <= '0;
        end else if (in_win && !win_end) begin
            win_reg <= win_reg + `DPA_WIN_W'(1);
        end
    end

    // One detector per pin pair, armed only inside the key window
    logic hit_jtag;
    logic hit_usb;
    dpa_acq_det u_det_jtag (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_arm(in_win),
        .i_clk_rise(tck_rise),
        .i_bit(p.tms),
        .o_hit(hit_jtag)
    );
    dpa_acq_det u_det_usb (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_arm(in_win),
        .i_clk_rise(dp_rise),
        .i_bit(p.usb_dm),
        .o_hit(hit_usb)
    );

    // Firmware controls
    wire fw_jtag_off = ctrl_reg[`DPA_C_JTAG_OFF];
    wire fw_swd_off = ctrl_reg[`DPA_C_SWD_OFF];
    wire dps_jtag = (dps_reg == `DPA_DPS_JTAG4) | (dps_reg == `DPA_DPS_JTAG5);
    wire tap_live = (mode_reg == dpa_pkg::M_JTAG)
        | (in_win & dps_jtag & ~fw_jtag_off & ~locked_reg);

    // Control register update on the test port
    wire tap_upd = tck_rise & (tap_reg == dpa_pkg::T_UDR) & tap_live;
    wire ctrl_upd = tap_upd & (ir_reg == `DPA_IR_CTRL);
    wire tap_swd_req = ctrl_upd & dr_reg[`DPA_TCTRL_SWD];

    // Port ownership; a single mode value keeps the pairs exclusive
    always_comb begin
        mode_next = mode_reg;
        unique case (mode_reg)
            dpa_pkg::M_WAIT: begin
                mode_next = dpa_pkg::M_WIN;
            end
            dpa_pkg::M_WIN: begin
                if (locked_reg) begin
                    mode_next = dpa_pkg::M_OFF;
                end else if (hit_usb) begin
                    mode_next = dpa_pkg::M_SWDU;
                end else if (hit_jtag || tap_swd_req) begin
                    mode_next = dpa_pkg::M_SWDJ;
                end else if (win_end) begin
                    if (dps_reg == `DPA_DPS_SWD) begin
                        mode_next = dpa_pkg::M_SWDJ;
                    end else if (dps_reg == `DPA_DPS_OFF || fw_jtag_off) begin
                        mode_next = dpa_pkg::M_OFF;
                    end else begin
                        mode_next = dpa_pkg::M_JTAG;
                    end
                end
            end
            dpa_pkg::M_JTAG: begin
                if (fw_jtag_off) begin
                    mode_next = dpa_pkg::M_OFF;
                end else if (tap_swd_req) begin
                    mode_next = dpa_pkg::M_SWDJ;
                end
            end
            dpa_pkg::M_SWDJ, dpa_pkg::M_SWDU: begin
                if (fw_swd_off) begin
                    mode_next = dpa_pkg::M_OFF;
                end else if (i_swd_jtag_reen) begin
                    mode_next = dpa_pkg::M_JTAG;
                end
            end
            dpa_pkg::M_OFF: begin
                mode_next = dpa_pkg::M_OFF;
            end
            default: begin
                mode_next = dpa_pkg::M_OFF;
            end
        endcase
    end

    // Every reset reopens the window, so a disabled port can be reacquired
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            mode_reg <= dpa_pkg::M_WAIT;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // Controller held in reset when the port is off or, in the JTAG5 setting only, the reset pin is low
    wire trst_en = (dps_reg == `DPA_DPS_JTAG5);
    wire tap_hold = ~tap_live | (trst_en & ~p.trst_n);
    wire tms = p.tms;

    // Controller next state; five high mode bits reach reset from anywhere
    always_comb begin
        unique case (tap_reg)
            dpa_pkg::T_TLR: tap_next = tms ? dpa_pkg::T_TLR : dpa_pkg::T_RTI;
            dpa_pkg::T_RTI: tap_next = tms ? dpa_pkg::T_SDR : dpa_pkg::T_RTI;
            dpa_pkg::T_SDR: tap_next = tms ? dpa_pkg::T_SIR : dpa_pkg::T_CDR;
            dpa_pkg::T_CDR: tap_next = tms ? dpa_pkg::T_E1DR : dpa_pkg::T_SHDR;
            dpa_pkg::T_SHDR: tap_next = tms ? dpa_pkg::T_E1DR : dpa_pkg::T_SHDR;
            dpa_pkg::T_E1DR: tap_next = tms ? dpa_pkg::T_UDR : dpa_pkg::T_PDR;
            dpa_pkg::T_PDR: tap_next = tms ? dpa_pkg::T_E2DR : dpa_pkg::T_PDR;
            dpa_pkg::T_E2DR: tap_next = tms ? dpa_pkg::T_UDR : dpa_pkg::T_SHDR;
            dpa_pkg::T_UDR: tap_next = tms ? dpa_pkg::T_SDR : dpa_pkg::T_RTI;
            dpa_pkg::T_SIR: tap_next = tms ? dpa_pkg::T_TLR : dpa_pkg::T_CIR;
            dpa_pkg::T_CIR: tap_next = tms ? dpa_pkg::T_E1IR : dpa_pkg::T_SHIR;
            dpa_pkg::T_SHIR: tap_next = tms ? dpa_pkg::T_E1IR : dpa_pkg::T_SHIR;
            dpa_pkg::T_E1IR: tap_next = tms ? dpa_pkg::T_UIR : dpa_pkg::T_PIR;
            dpa_pkg::T_PIR: tap_next = tms ? dpa_pkg::T_E2IR : dpa_pkg::T_PIR;
            dpa_pkg::T_E2IR: tap_next = tms ? dpa_pkg::T_UIR : dpa_pkg::T_SHIR;
            dpa_pkg::T_UIR: tap_next = tms ? dpa_pkg::T_SDR : dpa_pkg::T_RTI;
            default: tap_next = dpa_pkg::T_TLR;
        endcase
    end

    // Data register length follows the current instruction
    assign dr_len = (ir_reg == `DPA_IR_SCAN) ? `DPA_LEN_SCAN :
                    (ir_reg == `DPA_IR_CTRL) ? `DPA_LEN_CTRL : `DPA_LEN_BYP;

    // Shift toward the output; the input bit lands at the chosen length
    always_comb begin
        dr_sh = '0;
        for (int i = 0; i < `DPA_DR_W; i++) begin
            if (i == 32'(dr_len) - 1) begin
                dr_sh[i] = p.tdi;
            end else if (i < `DPA_DR_W - 1 && i < 32'(dr_len) - 1) begin
                dr_sh[i] = dr_reg[i + 1];
            end
        end
    end

    // Controller and its registers advance on the host clock's rising edge
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tap_reg <= dpa_pkg::T_TLR;
            ir_reg <= `DPA_IR_BYP;
            ir_sh_reg <= '0;
            dr_reg <= '0;
        end else if (tap_hold) begin
            tap_reg <= dpa_pkg::T_TLR;
            ir_reg <= `DPA_IR_BYP;
        end else if (tck_rise) begin
            tap_reg <= tap_next;
            unique case (tap_reg)
                dpa_pkg::T_TLR: ir_reg <= `DPA_IR_BYP;
                dpa_pkg::T_CIR: ir_sh_reg <= `DPA_IR_CAPT;
                dpa_pkg::T_SHIR: ir_sh_reg <= {p.tdi, ir_sh_reg[`DPA_IR_W-1:1]};
                dpa_pkg::T_UIR: ir_reg <= ir_sh_reg;
                dpa_pkg::T_CDR: begin
                    // Cells captured only on the test port
                    dr_reg <= (ir_reg == `DPA_IR_SCAN) ? i_bscan_in : '0;
                end
                dpa_pkg::T_SHDR: dr_reg <= dr_sh;
                default: begin
                end
            endcase
        end
    end

    // Output data changes on the falling host clock, driven only in shift
    wire tap_shift = (tap_reg == dpa_pkg::T_SHDR) | (tap_reg == dpa_pkg::T_SHIR);
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tdo_reg <= 1'b0;
            tdo_oe_reg <= 1'b0;
        end else if (tap_hold) begin
            tdo_oe_reg <= 1'b0;
        end else if (tck_fall) begin
            tdo_reg <= (tap_reg == dpa_pkg::T_SHIR) ? ir_sh_reg[0] : dr_reg[0];
            tdo_oe_reg <= tap_shift;
        end
    end

    // Scan outputs and reset request; serial wire never reaches these
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            scan_reg <= '0;
            rst_req_reg <= 1'b0;
        end else begin
            if (tap_upd && ir_reg == `DPA_IR_SCAN) begin
                scan_reg <= dr_reg;
            end
            rst_req_reg <= ctrl_upd & dr_reg[`DPA_TCTRL_RST]
                & (dps_reg != `DPA_DPS_OFF);
        end
    end

    // Firmware register decode
    wire sel_ctrl = (i_addr == `DPA_A_CTRL);
    wire sel_stat = (i_addr == `DPA_A_STAT);
    wire [31:0] stat_word = {23'h0, dps_reg, locked_reg, mode_reg};
    wire [31:0] rd_word = sel_ctrl ? {29'h0, ctrl_reg} :
                          sel_stat ? stat_word : 32'h0;

    // The debug enable has no path from the pins, only firmware sets it
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctrl_reg <= `DPA_CTRL_RST;
            rdata_reg <= '0;
        end else begin
            if (i_wr && sel_ctrl) begin
                ctrl_reg <= i_wdata[`DPA_CTRL_W-1:0];
            end
            rdata_reg <= i_rd ? rd_word : 32'h0;
        end
    end

    // Serial-wire data toward the protocol engine from the owning pair
    wire on_jp = (mode_reg == dpa_pkg::M_SWDJ);
    wire on_up = (mode_reg == dpa_pkg::M_SWDU);
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            swd_bit_reg <= 1'b0;
        end else begin
            swd_bit_reg <= on_up ? p.usb_dm : p.tms;
        end
    end
    assign o_swd_clk_rise = (on_jp & tck_rise) | (on_up & dp_rise);
    assign o_swd_bit = swd_bit_reg;

    // Pin drive; the mode pin is driven back only while serial wire owns it
    assign o_pins.tdo = tdo_reg;
    assign o_pins.tdo_oe = tdo_oe_reg & tap_live;
    assign o_pins.tms = i_swd_out;
    assign o_pins.tms_oe = on_jp & i_swd_oe;
    assign o_pins.usb_dm = i_swd_out;
    assign o_pins.usb_dm_oe = on_up & i_swd_oe;

    // State outputs
    assign o_bscan_out = scan_reg;
    assign o_rdata = rdata_reg;
    assign o_jtag_en = tap_live;
    assign o_swd_jtag_pair_en = on_jp;
    assign o_swd_usb_pair_en = on_up;
    assign o_dbg_trace_en = ctrl_reg[`DPA_C_DBG_EN] & ~locked_reg;
    assign o_locked = locked_reg;
    assign o_dev_rst_req = rst_req_reg;

endmodule
`default_nettype wire

//--- sim/dpa_top_chk.sv
// Checker of the debug port selection block, bound to its top
`timescale 1ns/1ps
`default_nettype none
`include "dpa_defs.svh"

module dpa_top_chk (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    // Settings and engine controls
    input wire logic [1:0] i_debug_port_select_setting,
    input wire logic i_swd_oe,
    input wire logic i_swd_jtag_reen,
    // Register port
    input wire logic [`DPA_ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    // Pins and port state
    input wire dpa_pkg::dpa_pin_out_t o_pins,
    input wire logic o_jtag_en,
    input wire logic o_swd_jtag_pair_en,
    input wire logic o_swd_usb_pair_en,
    input wire logic o_dbg_trace_en,
    input wire logic o_locked,
    input wire logic o_dev_rst_req
);
    logic [11:0] cyc_reg;
    logic [11:0] cyc_next;

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    // Cycles since release; saturates so late checks stay quiet
    assign cyc_next = (cyc_reg == 12'hfff) ? cyc_reg : cyc_reg + 12'h001;
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cyc_reg <= 12'h000;
        end else begin
            cyc_reg <= cyc_next;
        end
    end

    property p_one_pair;
        !(o_swd_jtag_pair_en && o_swd_usb_pair_en);
    endproperty
    a_one_pair: assert property (p_one_pair)
        else $error("serial wire on both pairs");

    property p_lock_off;
        o_locked |-> !(o_jtag_en || o_swd_jtag_pair_en
            || o_swd_usb_pair_en || o_dbg_trace_en);
    endproperty
    a_lock_off: assert property (p_lock_off)
        else $error("port live while locked");

    // Lock is taken once after release, later latch changes are ignored
    property p_lock_held;
        (cyc_reg > 12'h002) |-> $stable(o_locked);
    endproperty
    a_lock_held: assert property (p_lock_held)
        else $error("lock status moved after reset");

    property p_tms_oe;
        o_pins.tms_oe == (o_swd_jtag_pair_en && i_swd_oe);
    endproperty
    a_tms_oe: assert property (p_tms_oe)
        else $error("mode pin drive wrong");

    property p_usb_oe;
        o_pins.usb_dm_oe == (o_swd_usb_pair_en && i_swd_oe);
    endproperty
    a_usb_oe: assert property (p_usb_oe)
        else $error("usb data drive wrong");

    property p_rst_req;
        o_dev_rst_req |-> (i_debug_port_select_setting != `DPA_DPS_OFF)
            ##1 !o_dev_rst_req;
    endproperty
    a_rst_req: assert property (p_rst_req)
        else $error("device reset request wrong");

    property p_reen;
        o_swd_jtag_pair_en && i_swd_jtag_reen
            |=> o_jtag_en && !o_swd_jtag_pair_en;
    endproperty
    a_reen: assert property (p_reen)
        else $error("test port not handed back");

    property p_win;
        $rose(o_swd_usb_pair_en) |-> cyc_reg < 12'h64c;
    endproperty
    a_win: assert property (p_win)
        else $error("acquire outside key window");

    property p_swd_nvl;
        cyc_reg == 12'h64a && !o_locked
            && i_debug_port_select_setting == `DPA_DPS_SWD
            |-> o_swd_jtag_pair_en || o_swd_usb_pair_en;
    endproperty
    a_swd_nvl: assert property (p_swd_nvl)
        else $error("serial wire setting not honoured");

    property p_dbg;
        i_wr && i_addr == `DPA_A_CTRL && i_wdata[`DPA_C_DBG_EN] && !o_locked
            |=> ##[0:1] o_dbg_trace_en;
    endproperty
    a_dbg: assert property (p_dbg)
        else $error("debug enable write lost");

    // Main scenarios reached
    c_usb: cover property ($rose(o_swd_usb_pair_en));
    c_rst: cover property (o_dev_rst_req);
    c_reen: cover property (o_swd_jtag_pair_en && i_swd_jtag_reen);
endmodule

bind dpa_top dpa_top_chk i_chk (.*);
`default_nettype wire

//--- sim/dpa_probe.sv
// Host probe model driving the debug pins
`timescale 1ns/1ps
`default_nettype none
`include "dpa_defs.svh"

module dpa_probe (
    // Clock
    input wire logic i_clk_sys,
    // Device drive and resolved pin levels
    input wire dpa_pkg::dpa_pin_out_t i_dev,
    output dpa_pkg::dpa_pin_in_t o_pins
);
    localparam logic [15:0] PAT = `DPA_ACQ_PAT;
    logic ck = 1'b0, ms = 1'b0, di = 1'b0, dp = 1'b0, dm = 1'b0;
    logic tms_lv;
    logic dm_lv;

    // Device wins a shared data line while it drives it
    assign tms_lv = i_dev.tms_oe ? i_dev.tms : ms;
    assign dm_lv = i_dev.usb_dm_oe ? i_dev.usb_dm : dm;
    assign o_pins = {ck, tms_lv, di, 1'b1, dp, dm_lv};

    // One bit of 85 ns; clocks stand low between frames
    task automatic send(input logic usb, input logic s, input logic d);
        begin
            @(posedge i_clk_sys);
            if (usb) dm <= s; else ms <= s;
            di <= d;
            repeat (8) @(posedge i_clk_sys);
            if (usb) dp <= 1'b1; else ck <= 1'b1;
            repeat (8) @(posedge i_clk_sys);
            dp <= 1'b0;
            ck <= 1'b0;
        end
    endtask

    // Acquire sequence, first bit at the top; caller keeps the window
    task automatic acq(input logic usb);
        begin
            for (int i = 15; i >= 0; i--) begin
                send(usb, PAT[i], 1'b0);
            end
        end
    endtask

    // Controller reset by five ones, control instruction, 2-bit update
    task automatic jtag(input logic [1:0] dr);
        logic [21:0] tms_seq;
        logic [21:0] tdi_seq;
        begin
            tms_seq = 22'h3ec1c6;
            tdi_seq = {10'h000, 4'h1, 4'h0, dr[0], dr[1], 2'h0};
            for (int i = 21; i >= 0; i--) begin
                send(1'b0, tms_seq[i], tdi_seq[i]);
            end
        end
    endtask
endmodule
`default_nettype wire

//--- sim/dpa_top_test.sv
// Self-checking bench of the debug port selection block
`timescale 1ns/1ps
`default_nettype none
`include "dpa_defs.svh"

module dpa_top_test;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd_s = 1'b0;
    logic swd_oe = 1'b0, reen = 1'b0, swout = 1'b0, sbit;
    logic [1:0] sel = 2'h0;
    logic [3:0] addr = 4'h0;
    logic [31:0] lock = 32'h0, wdata = 32'h0;
    logic [31:0] rdata;
    logic jtag_en, jpair, upair, dbg, locked, rst_req;
    dpa_pkg::dpa_pin_in_t pins_in;
    dpa_pkg::dpa_pin_out_t pins_out;
    int n_fail = 0, tests_run = 0, n_rst = 0, cyc = 0;

    dpa_top i_dut (.i_clk_sys(clk), .i_sys_rst(rst),
        .i_debug_port_select_setting(sel), .i_write_once_lock_latch(lock),
        .i_pins(pins_in), .o_pins(pins_out), .i_bscan_in(8'h00),
        .o_bscan_out(), .o_swd_clk_rise(), .o_swd_bit(sbit), .i_swd_out(swout),
        .i_swd_oe(swd_oe), .i_swd_jtag_reen(reen), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd_s), .o_rdata(rdata),
        .o_jtag_en(jtag_en), .o_swd_jtag_pair_en(jpair),
        .o_swd_usb_pair_en(upair), .o_dbg_trace_en(dbg), .o_locked(locked),
        .o_dev_rst_req(rst_req));
    dpa_probe i_probe (.i_clk_sys(clk), .i_dev(pins_out), .o_pins(pins_in));

    // Clock, pulse count and hang guard
    initial begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rst_req === 1'b1) n_rst++;
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            stop_test();
        end
    end

    task automatic stop_test;
        if (n_fail == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Reset held 8 cycles; returns settled after the first edge
    task automatic restart(input logic [1:0] s, input logic [31:0] lk);
        @(posedge clk);
        rst <= 1'b1;
        sel <= s;
        lock <= lk;
        repeat (8) @(posedge clk);
        chk(32'({locked, jtag_en, jpair, upair, dbg}), 32'h10);
        rst <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 chk(rdata, exp);
    endtask

    task automatic t_regs;
        restart(`DPA_DPS_JTAG4, 32'h0);
        chk(32'(jtag_en), 32'h1);
        rd_reg(`DPA_A_STAT, 32'h2);
        rd_reg(`DPA_A_CTRL, 32'h0);
        rd_reg(4'h8, 32'h0);
        wr_reg(`DPA_A_CTRL, 32'h4);
        chk(32'(dbg), 32'h1);
        wr_reg(`DPA_A_CTRL, 32'h1);
        chk(32'({dbg, jtag_en}), 32'h0);
        @(posedge clk);
        lock <= `DPA_LOCK_KEY;
        repeat (3) @(posedge clk);
        chk(32'(locked), 32'h0);
    endtask

    task automatic t_usb;
        restart(`DPA_DPS_JTAG4, 32'h0);
        i_probe.acq(1'b1);
        repeat (6) @(posedge clk);
        swd_oe <= 1'b1;
        swout <= 1'b1;
        @(posedge clk);
        #1 chk(32'({upair, jpair, pins_out.usb_dm_oe, pins_out.tms_oe,
            pins_out.usb_dm, sbit}), 32'h2b);
        rd_reg(`DPA_A_STAT, 32'h10);
        wr_reg(`DPA_A_CTRL, 32'h2);
        chk(32'(upair), 32'h0);
        swd_oe <= 1'b0;
        swout <= 1'b0;
    endtask

    task automatic t_jpair;
        restart(`DPA_DPS_JTAG4, 32'h0);
        i_probe.acq(1'b0);
        repeat (6) @(posedge clk);
        #1 chk(32'({upair, jpair, jtag_en}), 32'h2);
        @(posedge clk);
        reen <= 1'b1;
        @(posedge clk);
        reen <= 1'b0;
        @(posedge clk);
        #1 chk(32'({jpair, jtag_en}), 32'h1);
    endtask

    task automatic t_window;
        restart(`DPA_DPS_JTAG4, 32'h0);
        repeat (1600) @(posedge clk);
        i_probe.acq(1'b1);
        repeat (6) @(posedge clk);
        #1 chk(32'({upair, jtag_en}), 32'h1);
        restart(`DPA_DPS_SWD, 32'h0);
        chk(32'({upair, jpair}), 32'h0);
        repeat (1610) @(posedge clk);
        #1 chk(32'({upair, jpair}), 32'h1);
    endtask

    // Four flipped key bits still lock, five do not
    task automatic t_lock;
        for (int i = 0; i < 2; i++) begin
            restart(`DPA_DPS_JTAG4, `DPA_LOCK_KEY ^ (i == 0 ? 32'hf : 32'h1f));
            i_probe.acq(1'b1);
            repeat (6) @(posedge clk);
            #1 chk(32'({locked, upair}), i == 0 ? 32'h2 : 32'h1);
        end
    endtask

    task automatic t_tap;
        for (int i = 0; i < 3; i++) begin
            restart(i == 2 ? `DPA_DPS_OFF : 2'(i), 32'h0);
            n_rst = 0;
            i_probe.jtag(2'h1);
            repeat (4) @(posedge clk);
            chk(32'(n_rst), i == 2 ? 32'h0 : 32'h1);
        end
        restart(`DPA_DPS_JTAG5, 32'h0);
        i_probe.jtag(2'h2);
        repeat (4) @(posedge clk);
        #1 chk(32'({jpair, jtag_en}), 32'h2);
    endtask

    // Main sequence
    initial begin
        t_regs();
        t_usb();
        t_jpair();
        t_window();
        t_lock();
        t_tap();
        stop_test();
    end
endmodule
`default_nettype wire
